// file: core/dlpwc_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module dlpwc_debounce #(
  parameter int unsigned N = 5,
  parameter int unsigned CW = 25,
  parameter int unsigned HOLD_CYC = 16000000,
  parameter int unsigned REP_CYC = 500000,
  parameter logic [N-1:0] REPEAT_MASK = '1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic [CW-1:0] db_cycles,
  // Buttons, low when closed
  input wire logic [N-1:0] btn_n,
  // One-cycle press events
  output logic [N-1:0] press
);
  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;
  logic [N-1:0] held_reg;
  logic [CW-1:0] dcnt_reg [N];
  logic [CW-1:0] hcnt_reg [N];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= btn_n;
      sync_reg <= meta_reg;
    end
  end

  // Contact must stay put for db_cycles both to close and to reopen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press <= '0;
      held_reg <= '0;
      for (int i = 0; i < N; i++) begin
        dcnt_reg[i] <= '0;
        hcnt_reg[i] <= '0;
      end
    end else if (!enable) begin
      press <= '0;
      held_reg <= '0;
      for (int i = 0; i < N; i++) begin
        dcnt_reg[i] <= '0;
        hcnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        press[i] <= 1'b0;
        if (!held_reg[i]) begin
          if (!sync_reg[i]) begin
            if (dcnt_reg[i] >= db_cycles - 1'b1) begin
              press[i] <= 1'b1;
              held_reg[i] <= 1'b1;
              dcnt_reg[i] <= '0;
              hcnt_reg[i] <= '0;
            end else begin
              dcnt_reg[i] <= dcnt_reg[i] + 1'b1;
            end
          end else begin
            dcnt_reg[i] <= '0;
          end
        end else if (sync_reg[i]) begin
          if (dcnt_reg[i] >= db_cycles - 1'b1) begin
            held_reg[i] <= 1'b0;
            dcnt_reg[i] <= '0;
          end else begin
            dcnt_reg[i] <= dcnt_reg[i] + 1'b1;
          end
        end else begin
          dcnt_reg[i] <= '0;
          // Long hold repeats after the hold time at the repeat rate
          if (REPEAT_MASK[i]) begin
            if (hcnt_reg[i] >= CW'(HOLD_CYC - 1)) begin
              press[i] <= 1'b1;
              hcnt_reg[i] <= CW'(HOLD_CYC - REP_CYC);
            end else begin
              hcnt_reg[i] <= hcnt_reg[i] + 1'b1;
            end
          end
        end
      end
    end
  end
endmodule // dlpwc_debounce
`default_nettype wire

// file: core/dlpwc_top.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dlpwc_map.svh"
module dlpwc_top #(
  parameter int unsigned CW = 25,
  parameter int unsigned BTN_READY_CYC = `DLPWC_BTN_READY_CYC,
  parameter int unsigned SLOW_DB_CYC = `DLPWC_SLOW_DB_CYC,
  parameter int unsigned HOLD_CYC = `DLPWC_HOLD_CYC,
  parameter int unsigned REP_CYC = `DLPWC_REP_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  input wire logic ser_enable,
  input wire logic ser_clk,
  input wire logic ser_data,
  output logic cascade_out,
  // Buttons, low when closed, and the speed select pin
  input wire logic ch0_attenuate_button,
  input wire logic ch0_gain_button,
  input wire logic ch1_attenuate_button,
  input wire logic ch1_gain_button,
  input wire logic mute_button_n,
  input wire logic speed_select,
  // Wiper positions and mute status
  output var dlpwc_pkg::dlpwc_pos_t wiper_terminal_zero,
  output var dlpwc_pkg::dlpwc_pos_t wiper_terminal_one,
  output logic hw_mute_active
);
  logic [2:0] lnk_meta_reg;
  logic [2:0] lnk_sync_reg;
  logic lnk_clk_prev_reg;
  logic lnk_en_prev_reg;
  logic mode_meta_reg;
  logic mode_sync_reg;
  logic mode_taken_reg;
  logic slow_mode_reg;
  logic [CW-1:0] up_cnt_reg;
  logic ser_ready_reg;
  logic btn_ready_reg;
  dlpwc_pkg::dlpwc_word_t shift_reg;
  logic [4:0] bit_cnt_reg;
  logic cout_reg;
  dlpwc_pkg::dlpwc_pos_t pos_reg [2];
  dlpwc_pkg::dlpwc_pos_t save_reg [2];
  logic hw_muted_reg;
  logic [4:0] press;
  logic en_s, clk_s, din_s, clk_rise, en_rise, ser_apply;
  logic apb_setup, apb_done, apb_wr_wiper, apb_mapped;
  logic [31:0] rd_val;

  function automatic dlpwc_pkg::dlpwc_pos_t word_to_pos(
    input logic [7:0] b);
    word_to_pos = b[`DLPWC_MUTE_BIT] ? `DLPWC_POS_MUTE
                                     : {1'b0, b[6:0]};
  endfunction

  function automatic dlpwc_pkg::dlpwc_pos_t step(
    input dlpwc_pkg::dlpwc_pos_t p, input logic att);
    if (att) begin
      step = (p >= `DLPWC_POS_LAST) ? p : p + 8'h01;
    end else if (p == `DLPWC_POS_MIN) begin
      step = p;
    end else if (p == `DLPWC_POS_MUTE) begin
      step = `DLPWC_POS_LAST;
    end else begin
      step = p - 8'h01;
    end
  endfunction

  // Link pins cross into pclk through two flops each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk_meta_reg <= '0;
      lnk_sync_reg <= '0;
      lnk_clk_prev_reg <= 1'b0;
      lnk_en_prev_reg <= 1'b0;
    end else begin
      lnk_meta_reg <= {ser_data, ser_clk, ser_enable};
      lnk_sync_reg <= lnk_meta_reg;
      lnk_clk_prev_reg <= lnk_sync_reg[1];
      lnk_en_prev_reg <= lnk_sync_reg[0];
    end
  end

  assign en_s = lnk_sync_reg[0];
  assign clk_s = lnk_sync_reg[1];
  assign din_s = lnk_sync_reg[2];
  assign clk_rise = clk_s && !lnk_clk_prev_reg;
  assign en_rise = en_s && !lnk_en_prev_reg;
  assign ser_apply = ser_ready_reg && lnk_en_prev_reg && !en_s &&
                     (bit_cnt_reg == `DLPWC_WORD_BITS);

  // Power-up timebase, independent of the serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt_reg <= '0;
      ser_ready_reg <= 1'b0;
      btn_ready_reg <= 1'b0;
    end else begin
      if (up_cnt_reg < CW'(BTN_READY_CYC)) begin
        up_cnt_reg <= up_cnt_reg + 1'b1;
      end
      ser_ready_reg <= up_cnt_reg >= CW'(`DLPWC_SER_READY_CYC - 1);
      btn_ready_reg <= up_cnt_reg >= CW'(BTN_READY_CYC);
    end
  end

  // Speed select taken once, after its synchroniser has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
      mode_taken_reg <= 1'b0;
      slow_mode_reg <= 1'b0;
    end else begin
      mode_meta_reg <= speed_select;
      mode_sync_reg <= mode_meta_reg;
      if (!mode_taken_reg && ser_ready_reg) begin
        slow_mode_reg <= mode_sync_reg;
        mode_taken_reg <= 1'b1;
      end
    end
  end

  // Serial shift path; current settings loaded at enable rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      cout_reg <= 1'b0;
    end else if (!ser_ready_reg || !en_s) begin
      bit_cnt_reg <= '0;
    end else if (en_rise) begin
      shift_reg <= {pos_reg[1], pos_reg[0]};
      cout_reg <= pos_reg[0][0];
      bit_cnt_reg <= '0;
    end else if (clk_rise) begin
      shift_reg <= {din_s, shift_reg[15:1]};
      cout_reg <= shift_reg[1];
      if (bit_cnt_reg <= `DLPWC_WORD_BITS) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // Wipers: serial, then APB, then mute, then buttons
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        pos_reg[i] <= `DLPWC_POS_LAST;
        save_reg[i] <= `DLPWC_POS_LAST;
      end
      hw_muted_reg <= 1'b0;
    end else if (ser_apply) begin
      pos_reg[0] <= word_to_pos(shift_reg[7:0]);
      pos_reg[1] <= word_to_pos(shift_reg[15:8]);
      hw_muted_reg <= 1'b0;
    end else if (apb_wr_wiper) begin
      pos_reg[0] <= word_to_pos(pwdata[7:0]);
      pos_reg[1] <= word_to_pos(pwdata[15:8]);
      hw_muted_reg <= 1'b0;
    end else if (press[4]) begin
      hw_muted_reg <= !hw_muted_reg;
      for (int i = 0; i < 2; i++) begin
        if (!hw_muted_reg) begin
          save_reg[i] <= pos_reg[i];
          pos_reg[i] <= `DLPWC_POS_MUTE;
        end else begin
          pos_reg[i] <= save_reg[i];
        end
      end
    end else if (|press[3:0]) begin
      hw_muted_reg <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        // Press while muted leaves mute, stepping from the saved place
        if (press[2*i] ^ press[2*i+1]) begin
          pos_reg[i] <= step(hw_muted_reg ? save_reg[i] : pos_reg[i],
                             press[2*i]);
        end else if (hw_muted_reg) begin
          pos_reg[i] <= save_reg[i];
        end
      end
    end
  end

  dlpwc_debounce #(
    .N(5),
    .CW(CW),
    .HOLD_CYC(HOLD_CYC),
    .REP_CYC(REP_CYC),
    .REPEAT_MASK(5'h0F)
  ) u_debounce (
    .pclk(pclk),
    .presetn(presetn),
    .enable(btn_ready_reg),
    .db_cycles(slow_mode_reg ? CW'(SLOW_DB_CYC)
                             : CW'(`DLPWC_FAST_DB_CYC)),
    .btn_n({mute_button_n, ch1_gain_button, ch1_attenuate_button,
            ch0_gain_button, ch0_attenuate_button}),
    .press(press)
  );

  // APB: one wait-free access cycle, answer registered at setup
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready;
  assign apb_mapped = (paddr == `DLPWC_OFF_STATUS) ||
                      (paddr == `DLPWC_OFF_WIPER);
  assign apb_wr_wiper = apb_done && pwrite && (paddr == `DLPWC_OFF_WIPER);

  always_comb begin
    rd_val = '0;
    rd_val[7:0] = pos_reg[0];
    rd_val[15:8] = pos_reg[1];
    if (paddr == `DLPWC_OFF_STATUS) begin
      rd_val[`DLPWC_ST_HWMUTE] = hw_muted_reg;
      rd_val[`DLPWC_ST_SLOW] = slow_mode_reg;
      rd_val[`DLPWC_ST_SER_RDY] = ser_ready_reg;
      rd_val[`DLPWC_ST_BTN_RDY] = btn_ready_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !apb_mapped;
      prdata <= (apb_setup && !pwrite && apb_mapped) ? rd_val : '0;
    end
  end

  assign wiper_terminal_zero = pos_reg[0];
  assign wiper_terminal_one = pos_reg[1];
  assign cascade_out = cout_reg;
  assign hw_mute_active = hw_muted_reg;

  property p_range;
    @(posedge pclk) disable iff (!presetn)
    pos_reg[0] <= `DLPWC_POS_MUTE && pos_reg[1] <= `DLPWC_POS_MUTE;
  endproperty
  a_range: assert property (p_range)
    else $error("wiper position above mute");

  property p_reset_pos;
    @(posedge pclk) $rose(presetn) |->
      pos_reg[0] == `DLPWC_POS_LAST && pos_reg[1] == `DLPWC_POS_LAST;
  endproperty
  a_reset_pos: assert property (p_reset_pos)
    else $error("wipers not at 127 after reset");

  property p_ser_ready;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ##[1:200] ser_ready_reg;
  endproperty
  a_ser_ready: assert property (p_ser_ready)
    else $error("serial port not ready in time");

  property p_btn_block;
    @(posedge pclk) disable iff (!presetn)
    !btn_ready_reg |-> press == 5'h00;
  endproperty
  a_btn_block: assert property (p_btn_block)
    else $error("button event before start-up delay");

  property p_idle;
    @(posedge pclk) disable iff (!presetn)
    !en_s |=> bit_cnt_reg == 5'h00 && $stable(shift_reg) && $stable(cout_reg);
  endproperty
  a_idle: assert property (p_idle)
    else $error("serial counter moved while disabled");

  property p_cout;
    @(posedge pclk) disable iff (!presetn)
    ser_ready_reg && en_s && !en_rise && clk_rise |=>
      cascade_out == $past(shift_reg[1]) && shift_reg[15] == $past(din_s);
  endproperty
  a_cout: assert property (p_cout)
    else $error("cascade bit or shift wrong");

  property p_mode_hold;
    @(posedge pclk) disable iff (!presetn)
    mode_taken_reg |=> $stable(slow_mode_reg) && mode_taken_reg;
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("speed select changed after capture");

  sequence s_ser_end;
    ser_apply ##1 1'b1;
  endsequence
  property p_apply;
    @(posedge pclk) disable iff (!presetn)
    ser_apply |-> s_ser_end and
      (##1 pos_reg[0] == word_to_pos($past(shift_reg[7:0])) &&
           pos_reg[1] == word_to_pos($past(shift_reg[15:8])));
  endproperty
  a_apply: assert property (p_apply)
    else $error("serial word not applied");

  property p_mute;
    @(posedge pclk) disable iff (!presetn)
    press[4] && !hw_muted_reg && !ser_apply && !apb_wr_wiper |=>
      pos_reg[0] == `DLPWC_POS_MUTE && pos_reg[1] == `DLPWC_POS_MUTE &&
      save_reg[0] == $past(pos_reg[0]) && hw_muted_reg;
  endproperty
  a_mute: assert property (p_mute)
    else $error("mute toggle failed");

  property p_sat;
    @(posedge pclk) disable iff (!presetn)
    press[1] && !press[0] && !press[4] && !ser_apply && !apb_wr_wiper &&
      !hw_muted_reg && pos_reg[0] == `DLPWC_POS_MIN |=>
      pos_reg[0] == `DLPWC_POS_MIN;
  endproperty
  a_sat: assert property (p_sat)
    else $error("gain step wrapped below zero");
endmodule // dlpwc_top
`default_nettype wire

// file: pkg/dlpwc_map.svh
// Overview of operation
// - Each channel holds a position 0 to 128; 128 is mute, 127 last before.
// - Reset sets both wiper positions to 127 with no host action.
// - Serial port accepts transfers within 10 us after reset release.
// - Buttons and mute are ignored until 50 ms after reset release.
// - Serial enable low keeps the serial port idle, clock and data ignored.
// - Data sampled on serial clock rising edge; host keeps it valid there.
// - Received serial bits become the new positions of both wipers.
// - One serial write carries both positions as two 8-bit words.
// - Each clocked-in bit shifts one bit of current settings out cascade.
// - Speed select high means slow debounce, low means fast debounce.
// - Speed select is captured once after reset; later changes ignored.
// - Attenuate press moves that wiper one step toward the output end.
// - Gain press moves that wiper one step toward the input end.
// - All button inputs are debounced and timed inside the block.
// - Mute button toggles: mute both, next press restores prior positions.
// - Each channel can also be muted by a serial command bit.
// - 16-bit word: bits 6:0 ch0, bit 7 mute ch0; 14:8 ch1, 15 mute ch1.
// - Positions apply only when enable falls after exactly 16 bits.
`ifndef DLPWC_MAP_SVH
`define DLPWC_MAP_SVH

`define DLPWC_POS_MUTE 8'h80
`define DLPWC_POS_LAST 8'h7F
`define DLPWC_POS_MIN 8'h00
`define DLPWC_WORD_BITS 5'h10
`define DLPWC_MUTE_BIT 7

`define DLPWC_OFF_STATUS 12'h000
`define DLPWC_OFF_WIPER 12'h004
`define DLPWC_ST_HWMUTE 16
`define DLPWC_ST_SLOW 17
`define DLPWC_ST_SER_RDY 18
`define DLPWC_ST_BTN_RDY 19

`define DLPWC_CLK_NS 50
`define DLPWC_T_SER_READY_NS 10000
`define DLPWC_T_BTN_READY_NS 50000000
`define DLPWC_T_FAST_DB_NS 50000
`define DLPWC_T_SLOW_DB_NS 1000000
`define DLPWC_T_HOLD_NS 800000000
`define DLPWC_T_REP_NS 25000000
`define DLPWC_CYC(t) (((t) + `DLPWC_CLK_NS - 1) / `DLPWC_CLK_NS)
`define DLPWC_SER_READY_CYC `DLPWC_CYC(`DLPWC_T_SER_READY_NS)
`define DLPWC_BTN_READY_CYC `DLPWC_CYC(`DLPWC_T_BTN_READY_NS)
`define DLPWC_FAST_DB_CYC `DLPWC_CYC(`DLPWC_T_FAST_DB_NS)
`define DLPWC_SLOW_DB_CYC `DLPWC_CYC(`DLPWC_T_SLOW_DB_NS)
`define DLPWC_HOLD_CYC `DLPWC_CYC(`DLPWC_T_HOLD_NS)
`define DLPWC_REP_CYC (`DLPWC_T_REP_NS / `DLPWC_CLK_NS)

`endif

// file: pkg/dlpwc_pkg.sv
package dlpwc_pkg;
  typedef logic [7:0] dlpwc_pos_t;
  typedef logic [15:0] dlpwc_word_t;
endpackage

// file: sim/dlpwc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dlpwc_host_model (
  // Serial link to the device
  output logic ser_enable,
  output logic ser_clk,
  output logic ser_data,
  // Settings coming back
  input wire logic cascade_out
);
  initial begin
    ser_enable = 1'b0;
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end

  // Pre clocks go out with the enable low; the clock idles low between frames
  task automatic send(input logic [15:0] word, input int nb, input int pre,
                      output logic [15:0] seen);
    seen = 16'h0000;
    // Keeps pin changes off the pclk edge
    #10;
    for (int k = 0; k < pre; k++) begin
      ser_data = ~ser_data;
      #200 ser_clk = 1'b1;
      #200 ser_clk = 1'b0;
    end
    #200 ser_enable = 1'b1;
    #200;
    for (int k = 0; k < nb; k++) begin
      ser_data = word[k % 16];
      #200 seen[k % 16] = cascade_out;
      ser_clk = 1'b1;
      #200 ser_clk = 1'b0;
    end
    #200 ser_enable = 1'b0;
    // Released line must not keep the last bit
    ser_data = ~ser_data;
  endtask
endmodule // dlpwc_host_model
`default_nettype wire

// file: sim/dlpwc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dlpwc_top_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hw;
  logic ser_enable, ser_clk, ser_data, cascade_out, speed_select;
  logic hw_mute_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] btn_n;
  logic [15:0] w;
  dlpwc_pkg::dlpwc_pos_t wiper_terminal_zero, wiper_terminal_one, cur0, cur1;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'h1A34729C;
  int i;

  // Shortened counts keep the run small
  dlpwc_top #(.BTN_READY_CYC(300), .SLOW_DB_CYC(40), .HOLD_CYC(200),
    .REP_CYC(50)) i_dlpwc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ser_enable(ser_enable), .ser_clk(ser_clk), .ser_data(ser_data),
    .cascade_out(cascade_out), .ch0_attenuate_button(btn_n[0]),
    .ch0_gain_button(btn_n[1]), .ch1_attenuate_button(btn_n[2]),
    .ch1_gain_button(btn_n[3]), .mute_button_n(btn_n[4]),
    .speed_select(speed_select), .wiper_terminal_zero(wiper_terminal_zero),
    .wiper_terminal_one(wiper_terminal_one), .hw_mute_active(hw_mute_active));

  dlpwc_host_model i_dlpwc_host_model (.ser_enable(ser_enable),
    .ser_clk(ser_clk), .ser_data(ser_data), .cascade_out(cascade_out));

  function automatic logic [7:0] dec(input logic [7:0] b);
    return b[7] ? 8'h80 : {1'b0, b[6:0]};
  endfunction

  function automatic logic [7:0] step(input logic [7:0] p, input logic att);
    if (att) return (p >= 8'h7F) ? p : p + 8'h01;
    return (p == 8'h00) ? p : p - 8'h01;
  endfunction

  function automatic logic [31:0] stat(input logic br, input logic sl);
    return {12'h000, br, 1'b1, sl, hw, cur1, cur0};
  endfunction

  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pos(input logic [7:0] got, input logic [7:0] exp);
    chk_word({24'h000000, got}, {24'h000000, exp});
  endtask

  task automatic chk_wipers();
    chk_pos(wiper_terminal_zero, hw ? 8'h80 : cur0);
    chk_pos(wiper_terminal_one, hw ? 8'h80 : cur1);
    chk_word({31'h0, hw_mute_active}, {31'h0, hw});
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send_word(input logic [15:0] wd, input int nb,
                           input int pre);
    logic [15:0] seen;
    i_dlpwc_host_model.send(wd, nb, pre, seen);
    repeat (8) @(posedge pclk);
    if (nb == 16) chk_word({16'h0, seen}, {16'h0, cur1, cur0});
    if (nb > 16) chk_word({31'h0, seen[0]}, {31'h0, wd[0]});
    if (nb == 16) begin
      cur0 = dec(wd[7:0]);
      cur1 = dec(wd[15:8]);
    end
    chk_wipers();
  endtask

  // Presses shorter than the debounce time must not count
  task automatic btn(input int b, input int lo);
    int c0;
    @(posedge pclk);
    c0 = cyc;
    btn_n[b] <= 1'b0;
    repeat (lo) @(posedge pclk);
    btn_n[b] <= 1'b1;
    repeat (80) @(posedge pclk);
    if (lo > 40 && c0 > 310) begin
      if (b < 2) cur0 = step(cur0, b == 0);
      else if (b < 4) cur1 = step(cur1, b == 2);
      else hw = ~hw;
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    btn_n = 5'h1F;
    speed_select = 1'b1;
    hw = 1'b0;
    cur0 = 8'h7F;
    cur1 = 8'h7F;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_wipers();
    repeat (210) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, stat(1'b0, 1'b1));
    btn(1, 50);
    chk_wipers();
    speed_select <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, stat(1'b1, 1'b1));
    for (i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'h8080 : (i == 1) ? 16'h7F00 : 16'($random(seed));
      send_word(w, 16, 0);
    end
    send_word(16'($random(seed)), 15, 0);
    send_word(16'($random(seed)), 17, 0);
    send_word(16'h0100, 16, 5);
    btn(1, 80);
    chk_wipers();
    for (i = 0; i < 8; i++) begin
      btn($unsigned($random(seed)) % 4, 80);
      chk_wipers();
    end
    btn(0, 10);
    chk_wipers();
    send_word(16'h7F7F, 16, 0);
    btn(0, 80);
    btn(2, 80);
    chk_wipers();
    btn(1, 80);
    btn(4, 80);
    chk_wipers();
    btn(4, 80);
    chk_wipers();
    w = 16'($random(seed));
    apb(1'b1, 12'h004, {16'h0, w});
    cur0 = dec(w[7:0]);
    cur1 = dec(w[15:8]);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(rd, {16'h0, cur1, cur0});
    chk_wipers();
    apb(1'b1, 12'h000, 32'($random(seed)));
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, stat(1'b1, 1'b1));
    apb(1'b0, 12'h008, 32'h0);
    chk_word({rd[30:0], err}, 32'h00000001);
    // Second power-up with the speed pin low must pick fast debounce
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    hw = 1'b0;
    cur0 = 8'h7F;
    cur1 = 8'h7F;
    @(posedge pclk);
    chk_wipers();
    repeat (210) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, stat(1'b0, 1'b0));
    print_verdict();
  end
endmodule // dlpwc_top_test
`default_nettype wire
